/* File: verif/mom_ovl_mem.sv */
// overlay memory model counting second segment hits
`timescale 1ns/1ps
`default_nettype none
module mom_ovl_mem (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic sel_i,
  input wire logic [13:0] addr_i,
  output logic [7:0] seg2_o
);
  // a13 splits the two 8k segments
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) seg2_o <= 8'h00;
    else if (sel_i && addr_i[13]) seg2_o <= seg2_o + 8'h01;
  end
endmodule // mom_ovl_mem
`default_nettype wire

/* File: verif/mom_properties.sv */
// port assertions for the overlay map block
`timescale 1ns/1ps
`default_nettype none
module mom_props (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pm_req_i,
  input wire logic [13:0] pm_addr_i,
  input wire logic dm_req_i,
  input wire logic [13:0] dm_addr_i,
  input wire logic access_done_o,
  input wire logic [13:0] ext_addr_o,
  input wire logic ext_pm_sel_o,
  input wire logic ext_dm_sel_o,
  input wire logic dm_reg_o,
  input wire logic [3:0] stack_ptr_o,
  input wire logic [9:0] imask_o,
  input wire logic [6:0] mode_status_reg_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  wire logic tk = access_done_o;
  property p_rdy; pready; endproperty
  property p_err; pslverr |-> psel && penable; endproperty
  property p_rst; $rose(rstn_i) |-> !stack_ptr_o && !imask_o && !mode_status_reg_o; endproperty
  property p_dmhi; dm_req_i && dm_addr_i[13] && tk |=> !ext_dm_sel_o; endproperty
  property p_pmlo; pm_req_i && !pm_addr_i[13] && tk |=> !ext_pm_sel_o; endproperty
  property p_pma;
    pm_req_i && tk |=> ext_pm_sel_o |-> ext_addr_o[12:0] == $past(pm_addr_i[12:0]);
  endproperty
  property p_dma;
    dm_req_i && !pm_req_i && tk |=> ext_dm_sel_o |-> ext_addr_o[12:0] == $past(dm_addr_i[12:0]);
  endproperty
  property p_reg; dm_req_i && dm_addr_i >= 14'h3fe0 && tk |=> dm_reg_o; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  a_err: assert property (p_err) else $error("pslverr outside access phase");
  a_rst: assert property (p_rst) else $error("reset state not cleared");
  a_dmhi: assert property (p_dmhi) else $error("upper data went external");
  a_pmlo: assert property (p_pmlo) else $error("lower program went external");
  a_pma: assert property (p_pma) else $error("program overlay address");
  a_dma: assert property (p_dma) else $error("data overlay address");
  a_reg: assert property (p_reg) else $error("mapped register missed");
  c_pm: cover property (ext_pm_sel_o);
  c_dm: cover property (ext_dm_sel_o);
  c_err: cover property (pslverr);
endmodule // mom_props
bind mom_top mom_props u_props (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .pm_req_i(pm_req_i),
  .pm_addr_i(pm_addr_i), .dm_req_i(dm_req_i), .dm_addr_i(dm_addr_i), .dm_reg_o(dm_reg_o),
  .access_done_o(access_done_o), .ext_addr_o(ext_addr_o), .ext_pm_sel_o(ext_pm_sel_o),
  .ext_dm_sel_o(ext_dm_sel_o), .stack_ptr_o(stack_ptr_o), .imask_o(imask_o),
  .mode_status_reg_o(mode_status_reg_o));
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the overlay map block
`timescale 1ns/1ps
`default_nettype none
`include "mom_defines.vh"
module testbench;
  logic ref_clk_i = 0, rstn_i = 0, psel = 0, penable = 0, pwrite = 0, mp = 0, bd = 0, err;
  logic br = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [3:0] q = 0;
  logic [13:0] a = 0;
  logic [7:0] pg = 0;
  wire [31:0] prdata;
  wire pready, pslverr, pm_s, dm_s, by_s, io_s, done, boot, run, ck;
  wire [13:0] ea, ff;
  wire [7:0] eh, hits;
  wire [3:0] sp;
  wire [9:0] im;
  wire [6:0] ms;
  int n_errors = 0, checked = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  mom_top dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .memory_map_mode_pin_i(mp), .bus_request_i(br), .boot_done_i(bd),
    .pm_req_i(q[3]), .pm_addr_i(a), .pm_fetch_i(q[3]), .fetch_addr_i(a), .dm_req_i(q[2]),
    .dm_addr_i(a), .byte_req_i(q[1]), .byte_addr_i(a), .byte_page_i(pg), .io_req_i(q[0]),
    .io_addr_i(a[10:0]), .ext_addr_o(ea), .ext_addr_hi_o(eh), .ext_pm_sel_o(pm_s),
    .ext_dm_sel_o(dm_s), .ext_byte_sel_o(by_s), .ext_io_sel_o(io_s), .pm_int_o(),
    .dm_int_o(), .dm_reg_o(), .fetch_int_o(), .fetch_ram_addr_o(), .access_done_o(done),
    .boot_run_o(boot), .core_run_o(run), .first_fetch_addr_o(ff), .stack_ptr_o(sp),
    .imask_o(im), .mode_status_reg_o(ms), .cycle_clock_output_o(ck));
  mom_ovl_mem u_mem (.clk_i(ref_clk_i), .rstn_i(rstn_i), .sel_i(pm_s | dm_s), .addr_i(ea),
    .seg2_o(hits));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int k;
    @(posedge ref_clk_i);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // one request sampled once, outputs looked at half a cycle later
  task automatic acc(input logic [3:0] r, input logic [13:0] ad);
    @(posedge ref_clk_i);
    q <= r;
    a <= ad;
    @(posedge ref_clk_i);
    q <= 4'h0;
    @(negedge ref_clk_i);
  endtask
  // short hold: the model has no pll to lock
  task automatic rst(input logic m);
    rstn_i <= 0;
    mp <= m;
    repeat (16) @(posedge ref_clk_i);
    rstn_i <= 1;
    repeat (3) @(posedge ref_clk_i);
  endtask
  task automatic t_boot;
    rst(0);
    chk("stack", 0, {sp, im, ms});
    chk("boot", 1, boot);
    bd <= 1;
    @(posedge ref_clk_i);
    bd <= 0;
    repeat (2) @(posedge ref_clk_i);
    chk("run", 1, run);
    chk("first", 0, ff);
    $display("test boot done");
  endtask
  task automatic t_route;
    logic x;
    for (int v = 0; v < 4; v++) begin
      x = v == 1 || v == 2;
      apb(1, `MOM_ADDR_PM_OVL, v);
      apb(1, `MOM_ADDR_DM_OVL, v);
      apb(0, `MOM_ADDR_PM_OVL, 0);
      chk("pm sel rd", v, rd);
      acc(4'h8, 14'h3abc);
      chk("pm ext", x, pm_s);
      if (x) chk("pm a", {v == 2, 13'h1abc}, ea);
      acc(4'h4, 14'h0abc);
      chk("dm ext", x, dm_s);
      if (x) chk("dm a", {v == 2, 13'h0abc}, ea);
      acc(4'h4, 14'h3fe4);
      chk("dm hi", 0, dm_s);
    end
    chk("seg2", 2, hits);
    pg <= 8'ha5;
    acc(4'h2, 14'h3c01);
    chk("byte", {1'b1, 8'ha5, 14'h3c01}, {by_s, eh, ea});
    acc(4'h1, 14'h07ff);
    chk("io", {1'b1, 11'h7ff}, {io_s, ea[10:0]});
    $display("test route done");
  endtask
  task automatic t_wait;
    int n;
    apb(1, `MOM_ADDR_DM_OVL, 1);
    apb(1, `MOM_ADDR_DATA_WAIT_STATES, 3);
    acc(4'h4, 14'h0010);
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk("waits", 3, n);
    acc(4'h4, 14'h2000);
    chk("int done", 1, done);
    apb(1, `MOM_ADDR_DATA_WAIT_STATES, 0);
    $display("test wait done");
  endtask
  task automatic t_clk;
    logic c;
    @(negedge ref_clk_i);
    c = ck;
    @(negedge ref_clk_i);
    chk("clk run", !c, ck);
    apb(1, `MOM_ADDR_CLKCTL, 1);
    repeat (2) @(negedge ref_clk_i);
    c = ck;
    @(negedge ref_clk_i);
    chk("clk off", c, ck);
    chk("clk low", 0, ck);
    $display("test clock done");
  endtask
  task automatic t_map;
    br <= 1;
    rst(1);
    chk("held", 2'b00, {boot, run});
    br <= 0;
    repeat (2) @(posedge ref_clk_i);
    chk("boot off", 2'b01, {boot, run});
    apb(1, `MOM_ADDR_DM_OVL, 1);
    acc(4'h4, 14'h0abc);
    chk("dm off", 0, dm_s);
    apb(1, `MOM_ADDR_PM_OVL, 1);
    apb(0, `MOM_ADDR_PM_OVL, 0);
    chk("pm forced", 0, rd);
    acc(4'h8, 14'h3abc);
    chk("pm int", 0, pm_s);
    apb(0, 12'hffc, 0);
    chk("unmapped", 1, err);
    $display("test map done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    t_boot;
    t_route;
    t_wait;
    t_clk;
    t_map;
    summarize;
  end
  initial begin
    #2000000;
    n_errors++;
    summarize;
  end
endmodule // testbench
`default_nettype wire

/* File: verilog/mom_defines.vh */
// constants for the memory overlay map and reset block
`ifndef MOM_DEFINES_VH
`define MOM_DEFINES_VH
`define MOM_ADDR_OVL_ID 12'h000
`define MOM_ADDR_PM_OVL 12'h004
`define MOM_ADDR_DM_OVL 12'h008
`define MOM_ADDR_DATA_WAIT_STATES 12'h00c
`define MOM_ADDR_CLKCTL 12'h010
`define MOM_ADDR_STATUS 12'h014
`define MOM_ADDR_MODE_STATUS_REG 12'h018
`define MOM_ADDR_BOOT 12'h01c
`define MOM_PM_OVL_LO 14'h2000
`define MOM_DM_OVL_HI 14'h1fff
`define MOM_DM_REG_BASE 14'h3fe0
`define MOM_OVL_RST 2'h0
`define MOM_DATA_WAIT_STATES_RST 3'h0
`define MOM_MODE_STATUS_REG_RST 7'h00
`define MOM_CLOCK_OUTPUT_DISABLE_RST 1'b0
`define MOM_STACK_EMPTY 4'h0
`define MOM_IMASK_RST 10'h000
`define MOM_BYTE_AW 22
`define MOM_IO_AW 11
`define MOM_OVL_ID_VALUE 32'h0000_5a01
`endif

/* File: verilog/mom_route.v */
// overlay decoder for one memory space
`timescale 1ns/1ps
`default_nettype none
module mom_route (
  input wire [13:0] addr_i,
  input wire [1:0] ovl_i,
  input wire in_window_i,
  input wire ovl_enable_i,
  output wire ext_o,
  output wire [13:0] ext_addr_o
);
  // reserved select values 3 and above stay internal
  wire ovl_valid = (ovl_i == 2'h1) || (ovl_i == 2'h2);
  assign ext_o = ovl_enable_i && ovl_valid && in_window_i;
  assign ext_addr_o = {(ovl_i == 2'h2), addr_i[12:0]};
endmodule // mom_route
`default_nettype wire

/* File: verilog/mom_top.v */
// memory overlay map, reset and clock output control
// Notes on behaviour
// - program space is 24 bits wide with 16K words on chip
// - program RAM allows fetch and data read in one cycle
// - program overlay select zero keeps all program words internal
// - program select 1 or 2 sends 0x2000-0x3fff to external bus
// - external A13 picks overlay 1 or 2, A12:0 low address bits
// - sequencer ignores program overlay select; loop hazard on change
// - overlay selects are not saved on the mode stack
// - memory map mode pin high disables boot and overlays
// - data space 16 bits, 16352 words plus 32 mapped registers
// - data overlay select zero keeps data internal
// - data select 1 or 2 sends 0x0000-0x1fff to external bus
// - data external A13 picks overlay, low 13 bits on A12:0
// - internal accesses one cycle, external data adds wait states
// - byte accesses use data lines as address, 22-bit byte address
// - io space has 2048 sixteen-bit locations
// - reset empties stacks, masks interrupts, clears mode status
// - after reset with map pin low, boot then fetch from zero
// - clock output at half the input clock rate, gated by disable bit
// - input clock runs at half the instruction rate
`timescale 1ns/1ps
`default_nettype none
`include "mom_defines.vh"
module mom_top (
  input wire ref_clk_i,
  input wire rstn_i,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire memory_map_mode_pin_i,
  input wire bus_request_i,
  input wire boot_done_i,
  input wire pm_req_i,
  input wire [13:0] pm_addr_i,
  input wire pm_fetch_i,
  input wire [13:0] fetch_addr_i,
  input wire dm_req_i,
  input wire [13:0] dm_addr_i,
  input wire byte_req_i,
  input wire [13:0] byte_addr_i,
  input wire [7:0] byte_page_i,
  input wire io_req_i,
  input wire [10:0] io_addr_i,
  output reg [13:0] ext_addr_o,
  output reg [7:0] ext_addr_hi_o,
  output reg ext_pm_sel_o,
  output reg ext_dm_sel_o,
  output reg ext_byte_sel_o,
  output reg ext_io_sel_o,
  output reg pm_int_o,
  output reg dm_int_o,
  output reg dm_reg_o,
  output reg fetch_int_o,
  output reg [13:0] fetch_ram_addr_o,
  output wire access_done_o,
  output wire boot_run_o,
  output wire core_run_o,
  output wire [13:0] first_fetch_addr_o,
  output wire [3:0] stack_ptr_o,
  output wire [9:0] imask_o,
  output wire [6:0] mode_status_reg_o,
  output reg cycle_clock_output_o
);
  localparam ST_RESET = 3'b001;
  localparam ST_BOOT = 3'b010;
  localparam ST_RUN = 3'b100;

  reg [1:0] pm_ovl_r;
  reg [1:0] dm_ovl_r;
  reg [2:0] data_wait_states_r;
  reg clock_output_disable_r;
  reg [6:0] mode_status_reg_r;
  reg [3:0] stack_r;
  reg [9:0] imask_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [2:0] wait_cnt_r;
  reg busy_r;
  reg map_mode_r;

  wire pm_ext;
  wire dm_ext;
  wire [13:0] pm_ext_addr;
  wire [13:0] dm_ext_addr;
  wire ovl_en = ~map_mode_r;

  // sequencer path never sees the select: fetch stays on the raw address
  mom_route u_pm_route (
    .addr_i(pm_addr_i),
    .ovl_i(pm_ovl_r),
    .in_window_i(pm_addr_i >= `MOM_PM_OVL_LO),
    .ovl_enable_i(ovl_en),
    .ext_o(pm_ext),
    .ext_addr_o(pm_ext_addr)
  );
  mom_route u_dm_route (
    .addr_i(dm_addr_i),
    .ovl_i(dm_ovl_r),
    .in_window_i(dm_addr_i <= `MOM_DM_OVL_HI),
    .ovl_enable_i(ovl_en),
    .ext_o(dm_ext),
    .ext_addr_o(dm_ext_addr)
  );

  // apb: zero-wait slave, writes on access phase
  wire apb_wr = psel && penable && pwrite;
  wire apb_rd = psel && !penable && !pwrite;
  reg addr_ok;
  always @* begin
    case (paddr)
      `MOM_ADDR_OVL_ID: addr_ok = 1'b1;
      `MOM_ADDR_PM_OVL: addr_ok = 1'b1;
      `MOM_ADDR_DM_OVL: addr_ok = 1'b1;
      `MOM_ADDR_DATA_WAIT_STATES: addr_ok = 1'b1;
      `MOM_ADDR_CLKCTL: addr_ok = 1'b1;
      `MOM_ADDR_STATUS: addr_ok = 1'b1;
      `MOM_ADDR_MODE_STATUS_REG: addr_ok = 1'b1;
      `MOM_ADDR_BOOT: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // map mode is caught after reset release, not in the reset branch
  reg strap_taken_r;
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_taken_r <= 1'b0;
      map_mode_r <= 1'b0;
    end else if (!strap_taken_r) begin
      strap_taken_r <= 1'b1;
      map_mode_r <= memory_map_mode_pin_i;
    end
  end

  // overlay selects live only here; no save on interrupt entry
  // map mode high pins the program select at zero
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      pm_ovl_r <= `MOM_OVL_RST;
    else if (apb_wr && paddr == `MOM_ADDR_PM_OVL)
      pm_ovl_r <= map_mode_r ? 2'h0 : pwdata[1:0];
  end

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      dm_ovl_r <= `MOM_OVL_RST;
    else if (apb_wr && paddr == `MOM_ADDR_DM_OVL)
      dm_ovl_r <= pwdata[1:0];
  end

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      data_wait_states_r <= `MOM_DATA_WAIT_STATES_RST;
    else if (apb_wr && paddr == `MOM_ADDR_DATA_WAIT_STATES)
      data_wait_states_r <= pwdata[2:0];
  end

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      clock_output_disable_r <= `MOM_CLOCK_OUTPUT_DISABLE_RST;
    else if (apb_wr && paddr == `MOM_ADDR_CLKCTL)
      clock_output_disable_r <= pwdata[0];
  end

  // stack and mask have no writer here: only master reset touches them
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_status_reg_r <= `MOM_MODE_STATUS_REG_RST;
      stack_r <= `MOM_STACK_EMPTY;
      imask_r <= `MOM_IMASK_RST;
    end else if (apb_wr && paddr == `MOM_ADDR_MODE_STATUS_REG) begin
      mode_status_reg_r <= pwdata[6:0];
    end
  end

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      prdata <= 32'h0000_0000;
    else if (apb_rd) begin
      case (paddr)
        `MOM_ADDR_OVL_ID: prdata <= `MOM_OVL_ID_VALUE; // arbitrary id value
        `MOM_ADDR_PM_OVL: prdata <= {30'h0, pm_ovl_r};
        `MOM_ADDR_DM_OVL: prdata <= {30'h0, dm_ovl_r};
        `MOM_ADDR_DATA_WAIT_STATES: prdata <= {29'h0, data_wait_states_r};
        `MOM_ADDR_CLKCTL: prdata <= {31'h0, clock_output_disable_r};
        `MOM_ADDR_STATUS: prdata <= {27'h0, busy_r, map_mode_r, state_r};
        `MOM_ADDR_MODE_STATUS_REG: prdata <= {25'h0, mode_status_reg_r};
        `MOM_ADDR_BOOT: prdata <= {31'h0, boot_run_o};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // reset sequencing: boot only with map pin low and no bus request
  always @* begin
    case (state_r)
      ST_RESET: begin
        if (!strap_taken_r || bus_request_i)
          state_nxt = ST_RESET;
        else if (!map_mode_r)
          state_nxt = ST_BOOT;
        else
          state_nxt = ST_RUN;
      end
      ST_BOOT: state_nxt = boot_done_i ? ST_RUN : ST_BOOT;
      ST_RUN: state_nxt = ST_RUN;
      default: state_nxt = ST_RESET;
    endcase
  end
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      state_r <= ST_RESET;
    else
      state_r <= state_nxt;
  end
  assign boot_run_o = state_r[1];
  assign core_run_o = state_r[2];
  assign first_fetch_addr_o = 14'h0000;
  assign stack_ptr_o = stack_r;
  assign imask_o = imask_r;
  assign mode_status_reg_o = mode_status_reg_r;

  // external data stretched by the wait-state count; all else one cycle
  wire dm_ext_go = dm_req_i && dm_ext && !busy_r;
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_r <= 1'b0;
      wait_cnt_r <= 3'h0;
    end else if (dm_ext_go && data_wait_states_r != 3'h0) begin
      busy_r <= 1'b1;
      wait_cnt_r <= data_wait_states_r;
    end else if (busy_r) begin
      wait_cnt_r <= wait_cnt_r - 3'h1;
      if (wait_cnt_r == 3'h1)
        busy_r <= 1'b0;
    end
  end
  assign access_done_o = !busy_r;

  // routing next values; everything holds while data wait states run
  reg [13:0] ext_addr_nxt;
  reg [7:0] ext_addr_hi_nxt;
  reg ext_pm_sel_nxt;
  reg ext_dm_sel_nxt;
  reg ext_byte_sel_nxt;
  reg ext_io_sel_nxt;
  reg pm_int_nxt;
  reg dm_int_nxt;
  reg dm_reg_nxt;
  reg fetch_int_nxt;
  reg [13:0] fetch_ram_addr_nxt;
  wire dm_low = dm_addr_i < `MOM_DM_REG_BASE;
  always @* begin
    ext_addr_nxt = ext_addr_o;
    ext_addr_hi_nxt = ext_addr_hi_o;
    ext_pm_sel_nxt = ext_pm_sel_o;
    ext_dm_sel_nxt = ext_dm_sel_o;
    ext_byte_sel_nxt = ext_byte_sel_o;
    ext_io_sel_nxt = ext_io_sel_o;
    pm_int_nxt = pm_int_o;
    dm_int_nxt = dm_int_o;
    dm_reg_nxt = dm_reg_o;
    fetch_int_nxt = fetch_int_o;
    fetch_ram_addr_nxt = fetch_ram_addr_o;
    if (!busy_r) begin
      // program RAM serves fetch and data together
      fetch_int_nxt = pm_fetch_i;
      fetch_ram_addr_nxt = fetch_addr_i;
      pm_int_nxt = pm_req_i && !pm_ext;
      ext_pm_sel_nxt = pm_req_i && pm_ext;
      dm_int_nxt = dm_req_i && !dm_ext && dm_low;
      dm_reg_nxt = dm_req_i && !dm_low;
      ext_dm_sel_nxt = dm_req_i && dm_ext;
      ext_byte_sel_nxt = byte_req_i && !pm_req_i && !dm_req_i;
      ext_io_sel_nxt = io_req_i && !pm_req_i && !dm_req_i && !byte_req_i;
      ext_addr_hi_nxt = 8'h00;
      if (pm_req_i && pm_ext) begin
        ext_addr_nxt = pm_ext_addr;
      end else if (dm_req_i && dm_ext) begin
        ext_addr_nxt = dm_ext_addr;
      end else if (byte_req_i) begin
        ext_addr_nxt = byte_addr_i;
        ext_addr_hi_nxt = byte_page_i;
      end else if (io_req_i) begin
        ext_addr_nxt = {3'h0, io_addr_i};
      end
    end
  end

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_addr_o <= 14'h0000;
      ext_addr_hi_o <= 8'h00;
      ext_pm_sel_o <= 1'b0;
      ext_dm_sel_o <= 1'b0;
      ext_byte_sel_o <= 1'b0;
      ext_io_sel_o <= 1'b0;
      pm_int_o <= 1'b0;
      dm_int_o <= 1'b0;
      dm_reg_o <= 1'b0;
      fetch_int_o <= 1'b0;
      fetch_ram_addr_o <= 14'h0000;
    end else begin
      ext_addr_o <= ext_addr_nxt;
      ext_addr_hi_o <= ext_addr_hi_nxt;
      ext_pm_sel_o <= ext_pm_sel_nxt;
      ext_dm_sel_o <= ext_dm_sel_nxt;
      ext_byte_sel_o <= ext_byte_sel_nxt;
      ext_io_sel_o <= ext_io_sel_nxt;
      pm_int_o <= pm_int_nxt;
      dm_int_o <= dm_int_nxt;
      dm_reg_o <= dm_reg_nxt;
      fetch_int_o <= fetch_int_nxt;
      fetch_ram_addr_o <= fetch_ram_addr_nxt;
    end
  end

  // clock out toggles on every ref_clk_i rising edge; held low when disabled
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      cycle_clock_output_o <= 1'b0;
    else if (clock_output_disable_r)
      cycle_clock_output_o <= 1'b0;
    else
      cycle_clock_output_o <= ~cycle_clock_output_o;
  end
endmodule // mom_top
`default_nettype wire
